/* rtl/pdc_cfg.svh */
// offsets, codes and sizes of the peripheral dma with crc block
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_NCH 9
`define PDC_NREQ 10
`define PDC_CRC_ID 4'h9
`define PDC_CH_END 8'h90
`define PDC_SEL_CTL 2'h0
`define PDC_SEL_SRC 2'h1
`define PDC_SEL_DST 2'h2
`define PDC_SEL_CNT 2'h3
`define PDC_STS 8'h90
`define PDC_MSK 8'h94
`define PDC_CCTL 8'ha0
`define PDC_SEED 8'ha4
`define PDC_CDATA 8'ha8
`define PDC_CSRC 8'hac
`define PDC_CLEN 8'hb0
`define PDC_DIR_P2M 2'h0
`define PDC_DIR_M2P 2'h1
`define PDC_DIR_M2M 2'h2
`define PDC_WID_WORD 2'h0
`define PDC_WID_HALF 2'h1
`define PDC_WID_BYTE 2'h2
`define PDC_HT_IDLE 2'h0
`define PDC_HT_NONSEQ 2'h2
`define PDC_HS_BYTE 3'h0
`define PDC_HS_HALF 3'h1
`define PDC_HS_WORD 3'h2
`define PDC_P_CCITT 2'h0
`define PDC_P_CRC8 2'h1
`define PDC_P_CRC16 2'h2
`define PDC_P_CRC32 2'h3
`define PDC_POLY_CCITT 32'h0000_1021
`define PDC_POLY_CRC8 32'h0000_0007
`define PDC_POLY_CRC16 32'h0000_8005
`define PDC_POLY_CRC32 32'h04c1_1db7
`endif

/* rtl/pdc_pkg.sv */
// types of the peripheral dma with crc block
`include "pdc_cfg.svh"
package pdc_pkg;
    typedef enum logic [2:0] {
        M_IDLE, M_RA, M_RD, M_CRC, M_WA, M_WD
    } pdc_mst_state_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } pdc_mst_t;

    typedef struct packed {
        logic [`PDC_NCH-1:0] en;
        logic [`PDC_NCH-1:0][1:0] dir;
        logic [`PDC_NCH-1:0][1:0] wid;
        logic [`PDC_NCH-1:0] sfix;
        logic [`PDC_NCH-1:0] dfix;
        logic [`PDC_NCH-1:0][31:0] src;
        logic [`PDC_NCH-1:0][31:0] dst;
        logic [`PDC_NCH-1:0][15:0] cnt;
        logic [`PDC_NREQ-1:0] sts;
        logic [`PDC_NREQ-1:0] msk;
        logic irq;
        logic [1:0] poly;
        logic irev;
        logic orev;
        logic iinv;
        logic oinv;
        logic cbusy;
        logic [31:0] seed;
        logic [31:0] crc;
        logic [31:0] csrc;
        logic [15:0] clen;
        logic [31:0] csh;
        logic [2:0] ccnt;
        logic pv;
        logic pwr;
        logic pcrc;
        logic [7:0] paddr;
        logic [2:0] psize;
        logic hrdy;
        logic [31:0] hrdata;
        pdc_mst_state_t ms;
        logic [3:0] cur;
        logic [31:0] buf_w;
        pdc_mst_t m;
        logic [`PDC_NCH-1:0] ack;
    } pdc_state_t;
endpackage : pdc_pkg

/* rtl/pdc_top.sv */
// nine channel peripheral dma engine with crc generator
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`include "pdc_cfg.svh"
module pdc_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // ahb-lite data master
    output pdc_pkg::pdc_mst_t m_bus,
    input wire logic [31:0] m_hrdata,
    input wire logic m_hready,
    // peripheral request and acknowledge
    input wire logic [`PDC_NCH-1:0] periph_req,
    output logic [`PDC_NCH-1:0] periph_ack,
    // interrupt
    output logic irq
);
    import pdc_pkg::*;

    pdc_state_t s;
    pdc_state_t n;
    logic accept;
    logic hit;
    logic [3:0] pick;
    logic [3:0] c;
    logic [7:0] b;
    logic [31:0] w;
    logic [2:0] nb;
    logic [`PDC_NREQ-1:0] rdy;

    function automatic logic [31:0] poly_of(input logic [1:0] p);
        case (p)
            `PDC_P_CCITT: poly_of = `PDC_POLY_CCITT;
            `PDC_P_CRC8: poly_of = `PDC_POLY_CRC8;
            `PDC_P_CRC16: poly_of = `PDC_POLY_CRC16;
            default: poly_of = `PDC_POLY_CRC32;
        endcase
    endfunction : poly_of

    function automatic logic [4:0] top_of(input logic [1:0] p);
        case (p)
            `PDC_P_CRC8: top_of = 5'h07;
            `PDC_P_CRC32: top_of = 5'h1f;
            default: top_of = 5'h0f;
        endcase
    endfunction : top_of

    function automatic logic [31:0] mask_of(input logic [1:0] p);
        mask_of = 32'hffff_ffff >> (5'h1f - top_of(p));
    endfunction : mask_of

    // one byte per cycle, msb first, keeps the checksum in the low bits
    function automatic logic [31:0] crc_byte(input logic [31:0] cv,
                                             input logic [7:0] d,
                                             input logic [1:0] p);
        logic [31:0] r;
        logic fb;
        r = cv;
        for (int i = 7; i >= 0; i--) begin
            fb = d[i] ^ r[top_of(p)];
            r = r << 1;
            if (fb) begin
                r = r ^ poly_of(p);
            end
            r = r & mask_of(p);
        end
        crc_byte = r;
    endfunction : crc_byte

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = d[7 - i];
        end
    endfunction : rev8

    function automatic logic [31:0] crc_out(input pdc_state_t st);
        logic [31:0] r;
        r = st.crc;
        if (st.orev) begin
            for (int i = 0; i < 32; i++) begin
                r[i] = st.crc[31 - i];
            end
            r = r >> (5'h1f - top_of(st.poly));
        end
        if (st.oinv) begin
            r = ~r & mask_of(st.poly);
        end
        crc_out = r;
    endfunction : crc_out

    function automatic logic [2:0] hs_of(input logic [1:0] wd);
        case (wd)
            `PDC_WID_WORD: hs_of = `PDC_HS_WORD;
            `PDC_WID_HALF: hs_of = `PDC_HS_HALF;
            default: hs_of = `PDC_HS_BYTE;
        endcase
    endfunction : hs_of

    function automatic logic [31:0] step_of(input logic [1:0] wd);
        case (wd)
            `PDC_WID_WORD: step_of = 32'h4;
            `PDC_WID_HALF: step_of = 32'h2;
            default: step_of = 32'h1;
        endcase
    endfunction : step_of

    // read value is fixed at the address phase, so a crc result read
    // must wait until the busy flag in the crc control word drops
    function automatic logic [31:0] rd_reg(input pdc_state_t st,
                                           input logic [7:0] a);
        logic [3:0] k;
        k = a[7:4];
        rd_reg = 32'h0;
        if (a < `PDC_CH_END) begin
            case (a[3:2])
                `PDC_SEL_CTL: rd_reg = {23'h0,
                    st.ms != M_IDLE && st.cur == k, 1'b0,
                    st.dfix[k], st.sfix[k], st.wid[k], st.dir[k],
                    st.en[k]};
                `PDC_SEL_SRC: rd_reg = st.src[k];
                `PDC_SEL_DST: rd_reg = st.dst[k];
                default: rd_reg = {16'h0, st.cnt[k]};
            endcase
        end else begin
            case (a)
                `PDC_STS: rd_reg = {22'h0, st.sts};
                `PDC_MSK: rd_reg = {22'h0, st.msk};
                `PDC_CCTL: rd_reg = {24'h0, st.cbusy || st.ccnt != 3'h0,
                    st.cbusy, st.oinv, st.iinv, st.orev, st.irev, st.poly};
                `PDC_SEED: rd_reg = st.seed;
                `PDC_CDATA: rd_reg = crc_out(st);
                `PDC_CSRC: rd_reg = st.csrc;
                `PDC_CLEN: rd_reg = {16'h0, st.clen};
                default: rd_reg = 32'h0;
            endcase
        end
    endfunction : rd_reg

    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        n = s;
        n.ack = '0;
        b = 8'h0;
        w = hwdata;
        c = s.cur;
        nb = 3'h0;
        hit = 1'b0;
        pick = 4'h0;

        // crc feeder: one byte each cycle, lowest byte first
        if (s.ccnt != 3'h0) begin
            b = s.csh[7:0];
            if (s.iinv) begin
                b = ~b;
            end
            if (s.irev) begin
                b = rev8(b);
            end
            n.crc = crc_byte(s.crc, b, s.poly);
            n.csh = s.csh >> 8;
            n.ccnt = s.ccnt - 3'h1;
        end
        // processor crc write waits for the feeder and for any crc dma run to end, then is stalled
        // for exactly one wait state
        if (s.pv && !s.hrdy && s.ccnt == 3'h0 && !s.cbusy) begin
            n.csh = hwdata;
            case (s.psize)
                `PDC_HS_BYTE: n.ccnt = 3'h1;
                `PDC_HS_HALF: n.ccnt = 3'h2;
                default: n.ccnt = 3'h4;
            endcase
            n.hrdy = 1'b1;
        end

        // register write in the data phase
        if (s.pv && s.hrdy) begin
            n.pv = 1'b0;
            if (s.pwr && !s.pcrc) begin
                c = s.paddr[7:4];
                if (s.paddr < `PDC_CH_END) begin
                    case (s.paddr[3:2])
                        `PDC_SEL_CTL: begin
                            n.en[c] = w[0];
                            n.dir[c] = w[2:1];
                            n.wid[c] = w[4:3];
                            n.sfix[c] = w[5];
                            n.dfix[c] = w[6];
                        end
                        `PDC_SEL_SRC: n.src[c] = w;
                        `PDC_SEL_DST: n.dst[c] = w;
                        default: n.cnt[c] = w[15:0];
                    endcase
                end else begin
                    case (s.paddr)
                        `PDC_STS: n.sts = s.sts & ~w[`PDC_NREQ-1:0];
                        `PDC_MSK: n.msk = w[`PDC_NREQ-1:0];
                        `PDC_CCTL: begin
                            n.poly = w[1:0];
                            n.irev = w[2];
                            n.orev = w[3];
                            n.iinv = w[4];
                            n.oinv = w[5];
                            if (w[6] && !s.cbusy) begin
                                n.cbusy = 1'b1;
                                n.crc = s.seed;
                            end
                        end
                        `PDC_SEED: begin
                            n.seed = w;
                            n.crc = w;
                        end
                        `PDC_CSRC: n.csrc = {w[31:2], 2'h0};
                        `PDC_CLEN: n.clen = w[15:0];
                        default: ;
                    endcase
                end
            end
        end

        // crc dma done sits after the status write so a set beats a clear
        if (s.cbusy && s.clen == 16'h0 && s.ccnt == 3'h0 &&
                s.ms == M_IDLE) begin
            n.cbusy = 1'b0;
            n.sts[`PDC_CRC_ID] = 1'b1;
        end

        // address phase
        if (accept) begin
            n.pv = 1'b1;
            n.pwr = hwrite;
            n.paddr = haddr[7:0];
            n.psize = hsize;
            n.pcrc = hwrite && haddr[7:0] == `PDC_CDATA;
            n.hrdy = !(hwrite && haddr[7:0] == `PDC_CDATA);
            n.hrdata = rd_reg(s, haddr[7:0]);
        end

        // requesters; a channel just acknowledged sits out one cycle
        // so a request still high from the last unit is not reused
        for (int k = 0; k < `PDC_NCH; k++) begin
            rdy[k] = s.en[k] && s.cnt[k] != 16'h0 && !s.ack[k] &&
                (s.dir[k] == `PDC_DIR_M2M || periph_req[k]);
        end
        rdy[`PDC_CRC_ID] = s.cbusy && s.clen != 16'h0;
        for (int k = `PDC_NREQ - 1; k >= 0; k--) begin
            if (rdy[k]) begin
                pick = 4'(k);
                hit = 1'b1;
            end
        end

        // data master: one unit at a time through the holding word
        case (s.ms)
            M_IDLE: begin
                if (hit) begin
                    n.cur = pick;
                    n.ms = M_RA;
                    n.m.htrans = `PDC_HT_NONSEQ;
                    n.m.hwrite = 1'b0;
                    if (pick == `PDC_CRC_ID) begin
                        n.m.haddr = s.csrc;
                        n.m.hsize = `PDC_HS_WORD;
                    end else begin
                        n.m.haddr = s.src[pick];
                        n.m.hsize = hs_of(s.wid[pick]);
                    end
                end
            end
            M_RA: begin
                if (m_hready) begin
                    n.m.htrans = `PDC_HT_IDLE;
                    n.ms = M_RD;
                end
            end
            M_RD: begin
                if (m_hready) begin
                    n.buf_w = m_hrdata;
                    if (s.cur == `PDC_CRC_ID) begin
                        n.ms = M_CRC;
                    end else begin
                        n.ms = M_WA;
                        n.m.haddr = s.dst[s.cur];
                        n.m.htrans = `PDC_HT_NONSEQ;
                        n.m.hwrite = 1'b1;
                    end
                end
            end
            M_CRC: begin
                if (s.ccnt == 3'h0) begin
                    nb = (s.clen >= 16'h4) ? 3'h4 : s.clen[2:0];
                    n.csh = s.buf_w;
                    n.ccnt = nb;
                    n.clen = s.clen - 16'(nb);
                    n.csrc = s.csrc + 32'h4;
                    n.ms = M_IDLE;
                end
            end
            M_WA: begin
                if (m_hready) begin
                    n.m.htrans = `PDC_HT_IDLE;
                    n.m.hwdata = s.buf_w;
                    n.ms = M_WD;
                end
            end
            M_WD: begin
                if (m_hready) begin
                    c = s.cur;
                    if (!s.sfix[c]) begin
                        n.src[c] = s.src[c] + step_of(s.wid[c]);
                    end
                    if (!s.dfix[c]) begin
                        n.dst[c] = s.dst[c] + step_of(s.wid[c]);
                    end
                    n.cnt[c] = s.cnt[c] - 16'h1;
                    if (s.dir[c] != `PDC_DIR_M2M) begin
                        n.ack[c] = 1'b1;
                    end
                    if (s.cnt[c] == 16'h1) begin
                        n.en[c] = 1'b0;
                        n.sts[c] = 1'b1;
                    end
                    n.ms = M_IDLE;
                end
            end
            default: n.ms = M_IDLE;
        endcase

        n.irq = |(n.sts & n.msk);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hrdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hrdy;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0;
    assign m_bus = s.m;
    assign periph_ack = s.ack;
    assign irq = s.irq;
endmodule : pdc_top

/* verif/pdc_properties.sv */
// port assertions of the dma with crc block
module pdc_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register slave
    input wire logic hreadyout,
    input wire logic hresp,
    // data master
    input pdc_pkg::pdc_mst_t m_bus,
    input wire logic m_hready,
    // handshake and interrupt
    input wire logic [8:0] periph_req,
    input wire logic [8:0] periph_ack,
    input wire logic irq
);
    import pdc_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_single_only: assert property (m_bus.htrans inside {2'h0, 2'h2})
        else $error("master htrans not single");
    a_addr_held: assert property (m_bus.htrans[1] && !m_hready
        |=> m_bus.htrans[1] && $stable(m_bus.haddr))
        else $error("master address not held");
    a_unit_gap: assert property (m_bus.htrans[1] && m_hready
        |=> m_bus.htrans == 2'h0) else $error("transfers not single");
    a_word_align: assert property (m_bus.htrans[1]
        && m_bus.hsize == 3'h2 |-> m_bus.haddr[1:0] == 2'h0)
        else $error("word access misaligned");
    a_ack_single: assert property ($onehot0(periph_ack))
        else $error("two acks at once");
    a_ack_on_req: assert property (|periph_ack
        |-> (periph_ack & ~$past(periph_req)) == 9'h0)
        else $error("ack without request");
    a_crc_wait: assert property ($fell(hreadyout)
        |-> ##[1:100] hreadyout) else $error("crc write wait too long");
    c_ack: cover property (|periph_ack);
    c_wait: cover property ($fell(hreadyout));
    c_irq: cover property ($rose(irq));
endmodule : pdc_chk

bind pdc_top pdc_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .m_bus(m_bus),
    .m_hready(m_hready), .periph_req(periph_req),
    .periph_ack(periph_ack), .irq(irq));

/* verif/pdc_mem.sv */
// memory and peripheral request model on the dma master side
module pdc_mem (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input pdc_pkg::pdc_mst_t m_bus,
    output logic [31:0] m_hrdata,
    output logic m_hready,
    // test control
    input wire logic slow,
    input wire logic [8:0] want,
    // peripheral handshake
    output logic [8:0] periph_req,
    input wire logic [8:0] periph_ack
);
    import pdc_pkg::*;
    logic [31:0] mem [0:255];
    logic dv, dw, wt;
    logic [31:0] da, junk;
    logic [2:0] ds;
    logic [3:0] be;
    // one wait state per data phase when slow, to stretch the master
    assign m_hready = !(slow && dv && !wt);
    // a released read bus shows a changing pattern, not stale data
    assign m_hrdata = (dv && !dw) ? mem[da[9:2]] : junk;
    assign be = (ds == 3'h0) ? 4'h1 << da[1:0] :
        (ds == 3'h1) ? 4'h3 << da[1:0] : 4'hf;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv <= 1'b0;
            wt <= 1'b0;
            junk <= 32'h5a5a_a5a5;
            periph_req <= 9'h0;
        end else begin
            junk <= ~junk;
            // request held until acked; the bench holds want meanwhile
            periph_req <= want & ~periph_ack;
            if (m_hready) begin
                for (int i = 0; i < 4; i++) begin
                    if (dv && dw && be[i])
                        mem[da[9:2]][8*i+:8] <= m_bus.hwdata[8*i+:8];
                end
                dv <= m_bus.htrans[1];
                dw <= m_bus.hwrite;
                da <= m_bus.haddr;
                ds <= m_bus.hsize;
                wt <= 1'b0;
            end else begin
                wt <= 1'b1;
            end
        end
    end
endmodule : pdc_mem

/* verif/tb_peripheral_dma_with_crc.sv */
// self-checking bench of the dma with crc block
`include "pdc_cfg.svh"
module tb_peripheral_dma_with_crc;
    timeunit 1ns;
    timeprecision 1ps;
    import pdc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic slow = 1'b0, rdy_q, hreadyout, hresp, m_hready, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_q, hrdata, m_hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [8:0] want = 9'h0, periph_req, periph_ack, first_ack;
    pdc_mst_t m_bus;
    int err_count = 0, checked = 0, acks = 0;

    pdc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .m_bus(m_bus),
        .m_hrdata(m_hrdata), .m_hready(m_hready),
        .periph_req(periph_req), .periph_ack(periph_ack), .irq(irq));
    pdc_mem u_mem (.hclk(hclk), .hresetn(hresetn), .m_bus(m_bus),
        .m_hrdata(m_hrdata), .m_hready(m_hready), .slow(slow),
        .want(want), .periph_req(periph_req), .periph_ack(periph_ack));

    initial forever #20 hclk = ~hclk;
    // registered outputs are steady here, so this equals the edge value
    always @(negedge hclk) begin
        rdy_q = hreadyout;
        rd_q = hrdata;
        if (|periph_ack) begin
            acks++;
            if (first_ack === 9'h0) first_ack = periph_ack;
        end
    end

    task automatic give_verdict;
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [2:0] sz, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= sz;
        do @(posedge hclk); while (!rdy_q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!rdy_q);
        r = rd_q;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 3'h2, r);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 3'h2, r);
        chk(r & m, e);
    endtask : rdchk

    task automatic cfg(input int c, input logic [31:0] t, s, d, n);
        wr(8'(c * 16 + 4), s);
        wr(8'(c * 16 + 8), d);
        wr(8'(c * 16 + 12), n);
        wr(8'(c * 16), t);
    endtask : cfg

    // polls status; gives up after 200 reads without a check, so a hang shows up in the later compares
    task automatic wait_done(input int b);
        logic [31:0] r;
        for (int i = 0; i < 200; i++) begin
            bus(1'b0, 8'h90, 32'h0, 3'h2, r);
            if (r[b] === 1'b1) break;
        end
    endtask : wait_done

    function automatic logic [31:0] crc_ref(input int w,
        input logic [31:0] poly, input logic [31:0] c, input logic [7:0] d);
        logic [31:0] m;
        m = (32'h1 << w) - 1;
        c = c ^ (32'(d) << (w - 8));
        for (int i = 0; i < 8; i++)
            c = c[w-1] ? ((c << 1) ^ poly) & m : (c << 1) & m;
        return c;
    endfunction : crc_ref

    task automatic t_regs;
        rdchk(8'h94, 32'hffff_ffff, 32'h0);
        wr(8'h14, 32'h1234_5678);
        rdchk(8'h14, 32'hffff_ffff, 32'h1234_5678);
        wr(8'hfc, 32'hffff_ffff);
        rdchk(8'hfc, 32'hffff_ffff, 32'h0);
        chk({31'h0, hresp}, 32'h0);
    endtask : t_regs

    task automatic t_m2m;
        slow <= 1'b1;
        u_mem.mem[8'h10] = 32'hcafe_0001;
        u_mem.mem[8'h11] = 32'h0bad_f00d;
        cfg(0, 32'h5, 32'h40, 32'h80, 32'h2);
        wait_done(0);
        chk(u_mem.mem[8'h20], 32'hcafe_0001);
        chk(u_mem.mem[8'h21], 32'h0bad_f00d);
        rdchk(8'h04, 32'hffff_ffff, 32'h48);
        rdchk(8'h00, 32'h1, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h94, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h90, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(8'h90, 32'h1, 32'h0);
        slow <= 1'b0;
    endtask : t_m2m

    task automatic t_p2m;
        u_mem.mem[8'h40] = 32'h4433_2211;
        u_mem.mem[8'h60] = 32'h0;
        acks = 0;
        cfg(1, 32'h31, 32'h100, 32'h180, 32'h3);
        want <= 9'h002;
        wait_done(1);
        want <= 9'h0;
        chk(u_mem.mem[8'h60], 32'h0033_2211);
        chk(32'(acks), 32'h3);
    endtask : t_p2m

    task automatic t_prio;
        first_ack = 9'h0;
        wr(8'h90, 32'h3ff);
        u_mem.mem[8'h70] = 32'h0;
        // channel 8: memory to peripheral, half-words, fixed destination
        cfg(8, 32'h4b, 32'h100, 32'h1c0, 32'h2);
        cfg(1, 32'h1, 32'h100, 32'h1c4, 32'h1);
        want <= 9'h102;
        wait_done(8);
        want <= 9'h0;
        chk({23'h0, first_ack}, 32'h2);
        chk(u_mem.mem[8'h70], 32'h0000_2211);
        chk(u_mem.mem[8'h71], 32'h4433_2211);
        rdchk(8'h84, 32'hffff_ffff, 32'h104);
        rdchk(8'h88, 32'hffff_ffff, 32'h1c0);
        rdchk(8'h90, 32'h102, 32'h102);
    endtask : t_prio

    task automatic t_stop;
        acks = 0;
        cfg(2, 32'h1, 32'h100, 32'h1d0, 32'h4);
        want <= 9'h004;
        for (int i = 0; i < 200 && acks == 0; i++) @(negedge hclk);
        wr(8'h20, 32'h0);
        // long enough for every remaining unit, had the stop been ignored
        repeat (60) @(negedge hclk);
        chk(32'(acks > 0 && acks < 3), 32'h1);
        rdchk(8'h90, 32'h4, 32'h0);
        want <= 9'h0;
    endtask : t_stop

    task automatic t_crc;
        logic [31:0] r, e, pl [4];
        int w [4];
        logic [1:0] p;
        logic [7:0] d;
        pl = '{`PDC_POLY_CCITT, `PDC_POLY_CRC8, `PDC_POLY_CRC16,
            `PDC_POLY_CRC32};
        w = '{16, 8, 16, 32};
        for (int k = 0; k < 8; k++) begin
            p = (k < 4) ? 2'(k) : (k == 7) ? 2'h2 : 2'h3;
            d = (k == 4) ? 8'h8c : (k == 7) ? 8'hce : 8'h31;
            e = crc_ref(w[p], pl[p], 32'ha5, d);
            if (k == 6) e = crc_ref(32, pl[3], e, 8'h32);
            if (k == 5) e = ~e;
            if (k == 7) begin
                r = 32'h0;
                for (int i = 0; i < 16; i++) r[i] = e[15 - i];
                e = r;
            end
            wr(8'ha0, {26'h0, k == 5, k == 7, k == 7, k == 4, p});
            wr(8'ha4, 32'ha5);
            bus(1'b1, 8'ha8, 32'h3231, (k == 6) ? 3'h1 : 3'h0, r);
            rdchk(8'ha8, (32'h1 << w[p]) - 1, e);
        end
        // dma mode: five bytes, so the second word is cut to one byte
        u_mem.mem[8'h10] = 32'hcafe_0001;
        u_mem.mem[8'h11] = 32'h0bad_f00d;
        e = 32'ha5;
        for (int i = 0; i < 5; i++) begin
            d = (i < 4) ? 8'(32'hcafe_0001 >> (8 * i)) : 8'h0d;
            e = crc_ref(32, pl[3], e, d);
        end
        wr(8'ha4, 32'ha5);
        wr(8'hac, 32'h43);
        wr(8'hb0, 32'h5);
        wr(8'ha0, 32'h43);
        wait_done(9);
        rdchk(8'ha8, 32'hffff_ffff, e);
        rdchk(8'hac, 32'hffff_ffff, 32'h48);
    endtask : t_crc

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_m2m();
        t_p2m();
        t_prio();
        t_stop();
        t_crc();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        give_verdict();
    end
endmodule : tb_peripheral_dma_with_crc
